// *** verilog/sec_err_defs.vh ***
// constants for the secondary error severity and first-error pointer registers
`ifndef SEC_ERR_DEFS_VH
`define SEC_ERR_DEFS_VH

// ==========================================
// register offsets in extended config space
`define SEV_OFFSET 12'h134
`define CAPCTL_OFFSET 12'h138

// ==========================================
// field layout and reset values
`define SEV_WIDTH 14
`define SEV_RESET 14'h1340
`define SEV_WRITE_MASK 14'h3FEE
`define SEV_REPORT_MASK 14'h1E8C
`define PTR_WIDTH 5
`define PTR_RESET 5'h00
`define SEV_PAD_WIDTH 18
`define PTR_PAD_WIDTH 27

// ==========================================
// pin input filter depth
`define PIN_SYNC_STAGES 3

`endif

// *** verilog/reset_sync.v ***
// two-flop release synchroniser for the power-on reset
`timescale 1ns/1ps
module reset_sync (
   input wire clk_sys,
   input wire nrst,
   output wire rst_n_out
);
   reg stage1_q;
   reg stage2_q;

   // assert at once, release only on a clock edge
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
      end else begin
         stage1_q <= 1'b1;
         stage2_q <= stage1_q;
      end
   end

   assign rst_n_out = stage2_q;
endmodule // reset_sync

// *** verilog/pin_filter.v ***
// three-flop pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
`include "sec_err_defs.vh"
module pin_filter (
   input wire clk_sys,
   input wire rst_n,
   input wire pin_in,
   output reg level_out
);
   reg [`PIN_SYNC_STAGES-1:0] sync_q;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_q <= {`PIN_SYNC_STAGES{1'b1}};
         level_out <= 1'b1;
      end else begin
         sync_q <= {sync_q[`PIN_SYNC_STAGES-2:0], pin_in};
         // stage one is never looked at here, only shifted on
         if (sync_q[1] == sync_q[2]) begin
            level_out <= sync_q[2];
         end
      end
   end
endmodule // pin_filter

// *** verilog/secondary_error_severity_regs.v ***
// secondary error severity register, first-error pointer and error message selection
`timescale 1ns/1ps
`include "sec_err_defs.vh"
module secondary_error_severity_regs (
   input wire clk_sys,
   input wire nrst,
   input wire perst_n,
   input wire global_reset_pin_n,
   input wire [11:0] cfg_addr,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   output reg [31:0] cfg_rdata,
   output reg cfg_ack,
   input wire [`SEV_WIDTH-1:0] err_detect,
   input wire [`SEV_WIDTH-1:0] status_held,
   output reg err_fatal_msg,
   output reg err_nonfatal_msg,
   output reg [`PTR_WIDTH-1:0] first_fault_pointer
);

   // ==========================================
   // functions

   // merge write data into an old word, byte lane by byte lane
   function [31:0] merge_bytes;
      input [31:0] old_word;
      input [31:0] new_word;
      input [3:0] lanes;
      integer i;
      begin
         merge_bytes = old_word;
         for (i = 0; i < 4; i = i + 1) begin
            if (lanes[i]) begin
               merge_bytes[i*8 +: 8] = new_word[i*8 +: 8];
            end
         end
      end
   endfunction

   // lowest set bit wins when several errors land in one cycle
   function [`PTR_WIDTH-1:0] lowest_set;
      input [`SEV_WIDTH-1:0] vec;
      integer i;
      begin
         lowest_set = `PTR_RESET;
         for (i = `SEV_WIDTH - 1; i >= 0; i = i - 1) begin
            if (vec[i]) begin
               lowest_set = i[`PTR_WIDTH-1:0];
            end
         end
      end
   endfunction

   // ==========================================
   // resets

   wire rst_n;
   wire perst_n_f;
   wire global_reset_pin_n_f;
   wire soft_clear;

   reset_sync u_reset_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .rst_n_out(rst_n)
   );

   pin_filter u_perst_filter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(perst_n),
      .level_out(perst_n_f)
   );

   pin_filter u_global_reset_pin_filter (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin_in(global_reset_pin_n),
      .level_out(global_reset_pin_n_f)
   );

   // fundamental and global reset act synchronously once filtered
   assign soft_clear = ~perst_n_f | ~global_reset_pin_n_f;

   // ==========================================
   // severity register

   reg [`SEV_WIDTH-1:0] sev_q;
   reg [`SEV_WIDTH-1:0] sev_d;
   wire sev_hit;
   wire ptr_hit;
   wire [31:0] sev_word;
   wire [31:0] ptr_word;
   wire [31:0] sev_merged;

   assign sev_hit = (cfg_addr == `SEV_OFFSET);
   assign ptr_hit = (cfg_addr == `CAPCTL_OFFSET);
   // reserved upper bits always read as zero
   assign sev_word = {{`SEV_PAD_WIDTH{1'b0}}, sev_q};
   assign ptr_word = {{`PTR_PAD_WIDTH{1'b0}}, first_fault_pointer};
   assign sev_merged = merge_bytes(sev_word, cfg_wdata, cfg_be);

   always @* begin
      sev_d = sev_q;
      if (soft_clear) begin
         sev_d = `SEV_RESET;
      end else if (cfg_wr && sev_hit) begin
         // bits 4 and 0 keep their zero; bits above 13 are not stored
         sev_d = (sev_merged[`SEV_WIDTH-1:0] & `SEV_WRITE_MASK)
            | (sev_q & ~`SEV_WRITE_MASK);
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sev_q <= `SEV_RESET;
      end else begin
         sev_q <= sev_d;
      end
   end

   // ==========================================
   // error message selection

   wire [`SEV_WIDTH-1:0] reportable;
   wire [`SEV_WIDTH-1:0] pending_reportable;

   // pci-x only bits never reach the message logic
   assign reportable = err_detect & `SEV_REPORT_MASK;
   assign pending_reportable = status_held & `SEV_REPORT_MASK;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         err_fatal_msg <= 1'b0;
         err_nonfatal_msg <= 1'b0;
      end else begin
         err_fatal_msg <= |(reportable & sev_q);
         err_nonfatal_msg <= |(reportable & ~sev_q);
      end
   end

   // ==========================================
   // first-error pointer

   reg latched_q;
   wire [`SEV_WIDTH-1:0] shifted_status;
   wire still_pending;
   wire released;

   // status is held outside; its bits clear only by a software one-write
   assign shifted_status = status_held >> first_fault_pointer;
   assign still_pending = shifted_status[0];
   assign released = latched_q & ~still_pending;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         first_fault_pointer <= `PTR_RESET;
         latched_q <= 1'b0;
      end else if (soft_clear) begin
         first_fault_pointer <= `PTR_RESET;
         latched_q <= 1'b0;
      end else if (!latched_q && (|reportable)) begin
         first_fault_pointer <= lowest_set(reportable);
         latched_q <= 1'b1;
      end else if (released && (|pending_reportable)) begin
         // an error that raced the clear is still pending: take it, not lose it
         first_fault_pointer <= lowest_set(pending_reportable);
         latched_q <= 1'b1;
      end else if (released && (|reportable)) begin
         first_fault_pointer <= lowest_set(reportable);
         latched_q <= 1'b1;
      end else if (released) begin
         // pointer keeps showing the last error until a new one arrives
         latched_q <= 1'b0;
      end
   end

   // ==========================================
   // configuration read and acknowledge

   reg [31:0] read_mux;

   always @* begin
      read_mux = 32'h0000_0000;
      if (sev_hit) begin
         read_mux = sev_word;
      end else if (ptr_hit) begin
         read_mux = ptr_word;
      end
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_rd | cfg_wr;
         if (cfg_rd) begin
            cfg_rdata <= read_mux;
         end else begin
            cfg_rdata <= 32'h0000_0000;
         end
      end
   end

endmodule // secondary_error_severity_regs

// *** verification/secondary_error_severity_regs_props.sv ***
// port checker for the severity and first-fault pointer block
`timescale 1ns/1ps
`include "sec_err_defs.vh"
module secondary_error_severity_regs_props (
   input wire clk_sys,
   input wire nrst,
   input wire perst_n,
   input wire global_reset_pin_n,
   input wire [11:0] cfg_addr,
   input wire cfg_wr,
   input wire cfg_rd,
   input wire [3:0] cfg_be,
   input wire [31:0] cfg_wdata,
   input wire [31:0] cfg_rdata,
   input wire cfg_ack,
   input wire [`SEV_WIDTH-1:0] err_detect,
   input wire [`SEV_WIDTH-1:0] status_held,
   input wire err_fatal_msg,
   input wire err_nonfatal_msg,
   input wire [`PTR_WIDTH-1:0] first_fault_pointer
);
   localparam [13:0] impl = 14'h1E8C;
   function automatic [4:0] low_bit(input [13:0] v);
      low_bit = 5'h00;
      for (int i = 13; i >= 0; i--)
         if (v[i]) low_bit = i[4:0];
   endfunction
   // ====
   // pin resets also blank the checks, but only while the raw pins are low, not while their filters settle after release
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst || !perst_n || !global_reset_pin_n);
   a_ack_follows: assert property (1'b1 |=> cfg_ack == $past(cfg_rd || cfg_wr))
      else $error("ack timing wrong");
   a_sev_reserved_bits: assert property (
      cfg_rd && cfg_addr == 12'h134 |=> (cfg_rdata & 32'hFFFF_C011) == 0)
      else $error("severity reserved bits set");
   a_ptr_reserved_bits: assert property (
      cfg_rd && cfg_addr == 12'h138 |=> cfg_rdata[31:5] == 0)
      else $error("pointer reserved bits set");
   a_fatal_cause: assert property (err_fatal_msg |-> ($past(err_detect) & impl) != 0)
      else $error("fatal without error");
   a_nonfatal_cause: assert property (err_nonfatal_msg |-> ($past(err_detect) & impl) != 0)
      else $error("nonfatal without error");
   a_quiet_unimpl: assert property (
      (err_detect & impl) == 0 |=> !err_fatal_msg && !err_nonfatal_msg)
      else $error("message from unimplemented error");
   a_msg_on_error: assert property (
      (err_detect & impl) != 0 |=> err_fatal_msg || err_nonfatal_msg)
      else $error("error not reported");
   a_ptr_held: assert property (status_held[first_fault_pointer] |=> $stable(first_fault_pointer))
      else $error("pointer moved while pending");
   a_ptr_capture: assert property (
      status_held == 0 && (err_detect & impl) != 0
      |=> first_fault_pointer == low_bit($past(err_detect) & impl))
      else $error("pointer not captured");
endmodule // secondary_error_severity_regs_props
bind secondary_error_severity_regs secondary_error_severity_regs_props u_props (.*);

// *** verification/status_model.sv ***
// far-side secondary uncorrectable status register model
`timescale 1ns/1ps
module status_model (
   input wire clk_sys,
   input wire nrst,
   input wire [13:0] err_detect,
   input wire [13:0] clr_mask,
   output reg [13:0] status_held
);
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) status_held <= 14'h0000;
      else status_held <= (status_held & ~clr_mask) | (err_detect & 14'h1E8C);
   end
endmodule // status_model

// *** verification/secondary_error_severity_regs_tb_top.sv ***
// self-checking bench for the severity and first-fault pointer block
`timescale 1ns/1ps
`include "sec_err_defs.vh"
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin mismatches++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module secondary_error_severity_regs_tb_top;
   logic clk_sys = 0, nrst = 0, perst_n = 1, global_reset_pin_n = 1, cfg_wr = 0, cfg_rd = 0;
   logic [11:0] cfg_addr = 0;
   logic [3:0] cfg_be = 0;
   logic [31:0] cfg_wdata = 0;
   logic [13:0] err_detect = 0, clr_mask = 0, sev;
   wire [13:0] status_held;
   wire [31:0] cfg_rdata;
   wire cfg_ack, err_fatal_msg, err_nonfatal_msg;
   wire [4:0] first_fault_pointer;
   logic [4:0] exp_ptr = 0;
   logic pend = 0;
   int mismatches = 0, samples_checked = 0, ib[7] = '{12, 11, 10, 9, 7, 3, 2};
   always #50 clk_sys = ~clk_sys;
   secondary_error_severity_regs DUT (.*);
   status_model far_end (.*);
   // ====
   // bus and error tasks, fixed one-cycle answer
   task automatic acc(input logic w, input [11:0] a, input [31:0] d, input [3:0] b,
                      input [31:0] e);
      @(posedge clk_sys);
      cfg_addr <= a;
      cfg_wdata <= d;
      cfg_be <= b;
      cfg_wr <= w;
      cfg_rd <= !w;
      @(posedge clk_sys);
      cfg_wr <= 0;
      cfg_rd <= 0;
      #1 `CHK("ack", 1'b1, cfg_ack)
      if (!w) `CHK("rdata", e, cfg_rdata)
   endtask
   task automatic wsev(input [31:0] d, input [3:0] b);
      logic [13:0] m;
      m = {{6{b[1]}}, {8{b[0]}}} & 14'h3FEE;
      acc(1, 12'h134, d, b, 0);
      sev = (sev & ~m) | (d[13:0] & m);
   endtask
   task automatic err(input int b);
      logic [13:0] mk;
      logic imp;
      mk = 14'h1E8C;
      imp = mk[b];
      @(posedge clk_sys);
      err_detect <= 14'h0001 << b;
      if (imp && !pend) begin
         exp_ptr = b[4:0];
         pend = 1;
      end
      @(posedge clk_sys);
      err_detect <= 0;
      #1 `CHK("fatal", imp & sev[b], err_fatal_msg)
      `CHK("nonfatal", imp & !sev[b], err_nonfatal_msg)
      `CHK("pointer", exp_ptr, first_fault_pointer)
   endtask
   task end_sim;
      if (mismatches == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ====
   // main sequence
   initial begin
      void'($urandom(32'h4ccbee70));
      sev = 14'h1340;
      repeat (5) @(posedge clk_sys);
      nrst <= 1;
      repeat (5) @(posedge clk_sys);
      acc(0, 12'h134, 0, 0, 32'h0000_1340);
      acc(1, 12'h138, 32'hFFFF_FFFF, 4'hF, 0);
      acc(0, 12'h138, 0, 0, 0);
      acc(0, 12'h13C, 0, 0, 0);
      repeat (6) begin
         wsev($urandom, 4'($urandom));
         acc(0, 12'h134, 0, 0, {18'h0_0000, sev});
      end
      for (int k = 0; k < 7; k++) begin
         wsev($urandom, 4'hF);
         err(ib[k]);
         err(ib[(k + 3) % 7]);
         err(k % 2 ? 13 : 5);
         @(posedge clk_sys);
         clr_mask <= 14'h3FFF;
         @(posedge clk_sys);
         clr_mask <= 0;
         pend = 0;
      end
      for (int p = 0; p < 2; p++) begin
         wsev(0, 4'h3);
         @(posedge clk_sys);
         if (p == 0) perst_n <= 0;
         else global_reset_pin_n <= 0;
         repeat (6) @(posedge clk_sys);
         perst_n <= 1;
         global_reset_pin_n <= 1;
         repeat (6) @(posedge clk_sys);
         sev = 14'h1340;
         acc(0, 12'h134, 0, 0, 32'h0000_1340);
         `CHK("pointer", 5'h00, first_fault_pointer)
      end
      end_sim;
   end
endmodule // secondary_error_severity_regs_tb_top
